//--- verilog/dhbmc_pkg.sv
// Constants for the dual bridge motor control logic
// Assumes a 50 MHz reference clock
package dhbmc_pkg;
   localparam int CLK_HZ          = 50000000;
   localparam int CLK_PERIOD_NS   = 20;
   // Chopping period
   localparam int PWM_FREQ_KHZ    = 50;
   localparam int PWM_CYCLES      = CLK_HZ / (PWM_FREQ_KHZ * 1000);
   // Blanking, least time, rounded up
   localparam int BLANK_NS        = 3750;
   localparam int BLANK_CYCLES    = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Overcurrent deglitch, least time
   localparam int OCP_DEG_NS      = 4000;
   localparam int OCP_DEG_CYCLES  = (OCP_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Dead time between leg partners
   localparam int DEAD_NS         = 450;
   localparam int DEAD_CYCLES     = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Overcurrent retry time and wake delay, in microseconds
   localparam int OCP_RETRY_US    = 1350;
   localparam int OCP_RETRY_CYC   = OCP_RETRY_US * (CLK_HZ / 1000000);
   localparam int WAKE_US         = 1000;
   localparam int WAKE_CYC        = WAKE_US * (CLK_HZ / 1000000);
   // Counter widths
   localparam int CNT_W           = 17;
   localparam int PWM_W           = 10;
   localparam int SHORT_W         = 8;
   // Reset value of drive outputs
   localparam logic RST_DRIVE     = 1'b0;

   typedef enum logic [1:0] {
      DHB_RUN   = 2'b00,
      DHB_TRIP  = 2'b01,
      DHB_RETRY = 2'b10
   } dhb_ocp_t;
endpackage

//--- verilog/dhbmc_top.sv
// Dual H-bridge control logic: truth table, chopping, protection, sleep and wake
// Assumes comparator, overcurrent, thermal and supply flags are synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Inputs 00 coast, 01 reverse, 10 forward, 11 brake, per bridge.
// - Fast decay turns all FETs off; slow decay turns both low sides on.
// - Sense trip forces both low sides on until next PWM period.
// - Sense flag ignored for 3.75 us after each period start.
// - Blanking acts as minimum on time of every chopping period.
// - Chop decision uses comparator flag for the 200 mV reference.
// - Chopping period runs from internal 50 kHz timebase, restarting drive.
// - Sleep low turns bridges off and holds all logic but the fault register in reset.
// - During sleep all inputs but supply low ignored; outputs high impedance unless supply low drives fault.
// - Outputs stay off for the 1 ms wake delay after sleep release.
// - Overcurrent past deglitch time turns bridge off and pulls fault low.
// - After retry time bridge re-enables and fault releases together.
// - Overcurrent shutdown touches only the bridge where it occurred.
// - High-side and low-side overcurrent flags watched apart from sense.
// - Overtemperature disables all FETs, pulls fault low, resumes by itself.
// - Supply low resets all logic but the fault register and disables bridge outputs until recovery.
// - Fault output pulled low during supply lockout.
// - Dead time inserted before a leg FET turns on after its partner.
module dhbmc_top
   import dhbmc_pkg::*;
#(
   parameter int OCP_RETRY_CYCLES = OCP_RETRY_CYC,
   parameter int WAKE_CYCLES      = WAKE_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       sleep_request_n,
   input  wire logic       supply_low_lockout,
   input  wire logic       overtemp_shutdown,
   input  wire logic [1:0] bridge_in_first,
   input  wire logic [1:0] bridge_in_second,
   input  wire logic [1:0] chop_trip,
   input  wire logic [1:0] ocp_high_side,
   input  wire logic [1:0] ocp_low_side,
   output logic      [1:0] out_first_high,
   output logic      [1:0] out_first_low,
   output logic      [1:0] out_second_high,
   output logic      [1:0] out_second_low,
   output logic            fault_flag_n_out,
   output logic            fault_flag_n_oe
);
   // Sleep or supply low resets all logic but the fault register
   wire       logicRstN = rst_n & sleep_request_n & ~supply_low_lockout;

   logic [CNT_W-1:0]   wakeCnt_r;
   logic               awake_r;
   logic [PWM_W-1:0]   pwmCnt_r;
   wire                pwmStart  = (pwmCnt_r == PWM_W'(PWM_CYCLES - 1));
   wire                blanking  = (pwmCnt_r < PWM_W'(BLANK_CYCLES));

   // Wake delay
   always_ff @(posedge ref_clk or negedge logicRstN) begin
      if (!logicRstN) begin
         wakeCnt_r <= '0;
         awake_r   <= 1'b0;
      end else if (!awake_r) begin
         wakeCnt_r <= wakeCnt_r + 1'b1;
         awake_r   <= (wakeCnt_r == CNT_W'(WAKE_CYCLES - 1));
      end
   end

   // Chopping timebase
   always_ff @(posedge ref_clk or negedge logicRstN) begin
      if (!logicRstN) begin
         pwmCnt_r <= '0;
      end else begin
         pwmCnt_r <= pwmStart ? '0 : pwmCnt_r + 1'b1;
      end
   end

   // Nets, since each bridge slice drives its own bit
   wire  [1:0] ocpFault;
   wire  [1:0] fhReq;
   wire  [1:0] flReq;
   wire  [1:0] shReq;
   wire  [1:0] slReq;

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bridge
         logic               chopped_r;
         logic [SHORT_W-1:0] degCnt_r;
         logic [CNT_W-1:0]   retryCnt_r;
         dhb_ocp_t           ocpSt_r;
         dhb_ocp_t           ocpSt_nxt;
         wire                inA     = bridge_in_first[b];
         wire                inB     = bridge_in_second[b];
         wire                ocpSeen = ocp_high_side[b] | ocp_low_side[b];
         wire                degDone = (degCnt_r == SHORT_W'(OCP_DEG_CYCLES));
         wire                retryDone = (retryCnt_r == CNT_W'(OCP_RETRY_CYCLES - 1));
         wire                enable  = awake_r & ~overtemp_shutdown & (ocpSt_r == DHB_RUN);
         wire                drive   = inA ^ inB;
         // Chopping state: slow decay until next period
         always_ff @(posedge ref_clk or negedge logicRstN) begin
            if (!logicRstN) begin
               chopped_r <= 1'b0;
            end else if (pwmStart) begin
               chopped_r <= 1'b0;
            end else if (chop_trip[b] && !blanking && drive) begin
               chopped_r <= 1'b1;
            end
         end
         // Overcurrent state machine
         always_comb begin
            ocpSt_nxt = ocpSt_r;
            unique case (ocpSt_r)
               DHB_RUN:   if (degDone) ocpSt_nxt = DHB_TRIP;
               DHB_TRIP:  ocpSt_nxt = DHB_RETRY;
               DHB_RETRY: if (retryDone) ocpSt_nxt = DHB_RUN;
               default:   ocpSt_nxt = DHB_RUN;
            endcase
         end
         always_ff @(posedge ref_clk or negedge logicRstN) begin
            if (!logicRstN) begin
               ocpSt_r    <= DHB_RUN;
               degCnt_r   <= '0;
               retryCnt_r <= '0;
            end else begin
               ocpSt_r    <= ocpSt_nxt;
               degCnt_r   <= (ocpSeen && ocpSt_r == DHB_RUN && !degDone) ?
                             degCnt_r + 1'b1 : '0;
               retryCnt_r <= (ocpSt_r == DHB_RETRY) ? retryCnt_r + 1'b1 : '0;
            end
         end
         // Truth table with chop override
         assign ocpFault[b] = (ocpSt_r != DHB_RUN);
         assign fhReq[b] = enable & inA & ~inB & ~chopped_r;
         assign shReq[b] = enable & ~inA & inB & ~chopped_r;
         assign flReq[b] = enable & (inB | chopped_r);
         assign slReq[b] = enable & (inA | chopped_r);
      end
   endgenerate

   // Per leg dead time: a FET turns on only after its partner was off long enough
   // Bit map: [1:0] first high, [3:2] first low, [5:4] second high, [7:6] second low
   wire  [7:0]         legOn;
   wire  [7:0]         legReq = {slReq, shReq, flReq, fhReq};

   generate
      for (b = 0; b < 4; b++) begin : g_leg
         // Leg b: high side at bit HI, its low side partner at bit LO
         localparam int HI = (b < 2) ? b     : b + 2;
         localparam int LO = (b < 2) ? b + 2 : b + 4;
         logic               hiOut_r;
         logic               loOut_r;
         logic [SHORT_W-1:0] deadCnt_r;
         wire                legSw = (legReq[HI] != hiOut_r) | (legReq[LO] != loOut_r);
         // Any change first turns the whole leg off, then waits out the dead time
         always_ff @(posedge ref_clk or negedge logicRstN) begin
            if (!logicRstN) begin
               deadCnt_r <= '0;
               hiOut_r   <= RST_DRIVE;
               loOut_r   <= RST_DRIVE;
            end else if (legSw && (hiOut_r | loOut_r)) begin
               hiOut_r   <= 1'b0;
               loOut_r   <= 1'b0;
               deadCnt_r <= '0;
            end else if (deadCnt_r < SHORT_W'(DEAD_CYCLES)) begin
               deadCnt_r <= deadCnt_r + 1'b1;
            end else begin
               hiOut_r   <= legReq[HI];
               loOut_r   <= legReq[LO] & ~legReq[HI];
            end
         end
         assign legOn[HI] = hiOut_r;
         assign legOn[LO] = loOut_r;
      end
   endgenerate

   // Fault output register
   logic faultOe_r;
   wire  faultNow = ocpFault[0] | ocpFault[1] | overtemp_shutdown;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         faultOe_r <= 1'b0;
      end else begin
         faultOe_r <= faultNow & sleep_request_n | supply_low_lockout;
      end
   end

   assign out_first_high   = legOn[1:0];
   assign out_first_low    = legOn[3:2];
   assign out_second_high  = legOn[5:4];
   assign out_second_low   = legOn[7:6];
   assign fault_flag_n_out = 1'b0;
   assign fault_flag_n_oe  = faultOe_r;

   // Assertions
   a_sleep_outputs_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !sleep_request_n |=> (legOn == 8'h00))
      else $error("Bridge FET on during sleep");
   a_no_shoot_thru: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !((legOn[0] & legOn[2]) | (legOn[1] & legOn[3]) |
        (legOn[4] & legOn[6]) | (legOn[5] & legOn[7])))
      else $error("Leg cross conduction");
   a_wake_hold_off: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      $rose(logicRstN) |-> (legOn == 8'h00) [*8])
      else $error("Drive during wake delay");
   a_ocp_fault_low: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      (g_bridge[0].ocpSt_r == DHB_TRIP) |=> faultOe_r)
      else $error("Fault not asserted on overcurrent");
   a_ocp_bridge_off: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      (g_bridge[1].ocpSt_r != DHB_RUN) |-> !fhReq[1] && !shReq[1] && !flReq[1] && !slReq[1])
      else $error("Tripped bridge still requested");
   a_temp_fault: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      overtemp_shutdown |-> (legReq == 8'h00) ##1 faultOe_r)
      else $error("Overtemperature not handled");
   a_chop_clear: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      pwmStart |=> !g_bridge[0].chopped_r && !g_bridge[1].chopped_r)
      else $error("Chop not cleared at period start");
   a_blank_nochop: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      blanking && !pwmStart |=> !$rose(g_bridge[0].chopped_r))
      else $error("Chop during blanking");
   a_supply_low_lockout_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
      supply_low_lockout |=> faultOe_r)
      else $error("Fault not asserted in lockout");

   // Truth table on bridge A requests
   a_coast_no_req: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      !bridge_in_first[0] && !bridge_in_second[0] && !g_bridge[0].chopped_r
      |-> ((legReq & 8'h55) == 8'h00))
      else $error("Coast still requests a FET");
   a_fwd_req: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      g_bridge[0].enable && bridge_in_first[0] && !bridge_in_second[0] && !g_bridge[0].chopped_r
      |-> ((legReq & 8'h55) == 8'h41))
      else $error("Forward decode wrong");
   a_rev_req: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      g_bridge[0].enable && !bridge_in_first[0] && bridge_in_second[0] && !g_bridge[0].chopped_r
      |-> ((legReq & 8'h55) == 8'h14))
      else $error("Reverse decode wrong");
   a_brake_req: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      g_bridge[0].enable && bridge_in_first[0] && bridge_in_second[0]
      |-> ((legReq & 8'h55) == 8'h44))
      else $error("Brake decode wrong");

   // Chopping
   a_chop_low_sides: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      g_bridge[0].enable && g_bridge[0].chopped_r
      |-> ((legReq & 8'h55) == 8'h44))
      else $error("Chopped bridge not in slow decay");
   a_chop_needs_drive: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      !g_bridge[0].drive
      |=> !$rose(g_bridge[0].chopped_r))
      else $error("Chop while bridge not driving");
   a_pwm_wrap: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      pwmStart
      |=> (pwmCnt_r == '0))
      else $error("Chopping period did not restart");

   // Wake, sleep and lockout
   a_wake_no_req: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      !awake_r
      |-> (legReq == 8'h00))
      else $error("Drive requested before wake");
   a_sleep_fault_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !sleep_request_n && !supply_low_lockout
      |=> !faultOe_r)
      else $error("Fault driven during sleep");
   a_supply_low_lockout_outputs_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      supply_low_lockout
      |-> (legOn == 8'h00))
      else $error("FET on during lockout");

   // Overcurrent sequence
   a_ocp_trip_off: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      (g_bridge[0].ocpSt_r != DHB_RUN)
      |-> ((legReq & 8'h55) == 8'h00))
      else $error("Tripped bridge A still requested");
   a_ocp_to_retry: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      (g_bridge[0].ocpSt_r == DHB_TRIP)
      |=> (g_bridge[0].ocpSt_r == DHB_RETRY))
      else $error("Trip did not enter retry");
   a_retry_fault_held: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      (g_bridge[0].ocpSt_r == DHB_RETRY)
      |=> faultOe_r)
      else $error("Fault released during retry");
   a_retry_ends: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      (g_bridge[0].ocpSt_r == DHB_RETRY) && g_bridge[0].retryDone
      |=> (g_bridge[0].ocpSt_r == DHB_RUN))
      else $error("Retry did not re-enable bridge");
   a_other_bridge_on: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      (g_bridge[0].ocpSt_r != DHB_RUN) && g_bridge[1].enable && !g_bridge[1].chopped_r &&
      bridge_in_first[1] && !bridge_in_second[1]
      |-> ((legReq & 8'hAA) == 8'h82))
      else $error("Healthy bridge stopped by other trip");

   // Fault line
   a_fault_on_any: assert property (@(posedge ref_clk) disable iff (!rst_n)
      faultNow && sleep_request_n
      |=> faultOe_r)
      else $error("Fault not driven on trip");
   a_fault_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !faultNow && !supply_low_lockout
      |=> !faultOe_r)
      else $error("Fault driven with no cause");

   // Dead time after a leg FET turns off
   a_dead_first_a: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      $fell(legOn[0])
      |=> !legOn[2] [*8])
      else $error("Low side on too soon after high side");
   a_dead_second_a: assert property (@(posedge ref_clk) disable iff (!logicRstN)
      $fell(legOn[6])
      |=> !legOn[4] [*8])
      else $error("High side on too soon after low side");
endmodule

`default_nettype wire

//--- test/dhbmc_host_model.sv
// Host model: drives the bridge and sleep pins and reads the open-drain fault line
// Assumes the bench changes its requests at the falling edge of ref_clk
`timescale 1ns/100ps
`default_nettype none
module dhbmc_host_model #(
   parameter int WAKE_CYCLES = 30
) (
   input  wire logic       ref_clk,
   input  wire logic [1:0] reqFirst,
   input  wire logic [1:0] reqSecond,
   input  wire logic       reqSleepN,
   input  wire logic       fault_flag_n_out,
   input  wire logic       fault_flag_n_oe,
   output logic      [1:0] bridge_in_first,
   output logic      [1:0] bridge_in_second,
   output logic            sleep_request_n,
   output logic            faultLineN,
   output logic            wakeDone
);
   int wakeCnt = 0;
   // Pull-up keeps the line high unless the device sinks it
   assign faultLineN = fault_flag_n_oe ? fault_flag_n_out : 1'b1;
   // Decay mode follows from the levels held on the second input
   assign bridge_in_first  = reqFirst;
   assign bridge_in_second = reqSecond;
   assign sleep_request_n  = reqSleepN;
   // Drive is not expected before the wake delay has run out
   always @(posedge ref_clk) begin
      wakeCnt = reqSleepN ? wakeCnt + 1 : 0;
   end
   assign wakeDone = wakeCnt > WAKE_CYCLES;
endmodule
`default_nettype wire

//--- test/test_dual_hbridge_motor_control.sv
// Bench for the dual bridge control logic, table of truth-table rows then protection cases
// Assumes a 50 MHz clock and shortened retry and wake counts
`timescale 1ns/100ps
`default_nettype none
module test_dual_hbridge_motor_control
   import dhbmc_pkg::*;
;
   localparam int RETRY = 40;
   localparam int WAKE  = 30;
   logic       ref_clk = 1'b0, rst_n = 1'b0, reqSleepN = 1'b1, lowSupply = 1'b0, hotDie = 1'b0;
   logic [1:0] reqFirst = 2'b00, reqSecond = 2'b00, chopTrip = 2'b00;
   logic [1:0] ocpHigh = 2'b00, ocpLow = 2'b00, inFirst, inSecond, fh, fl, sh, sl;
   logic       sleepN, fOut, fOe, faultLineN, wakeDone;
   logic [7:0] fets;
   int         miscompares = 0, compares = 0, n, k;
   // Each row: first inputs, second inputs, expected {fh, fl, sh, sl}
   logic [11:0] rows [6] = '{12'h441, 12'h114, 12'hF33, 12'h996, 12'h000, 12'h669};
   always #10 ref_clk = ~ref_clk;
   dhbmc_host_model #(.WAKE_CYCLES(WAKE)) i_host (.ref_clk(ref_clk), .reqFirst(reqFirst),
      .reqSecond(reqSecond), .reqSleepN(reqSleepN), .fault_flag_n_out(fOut),
      .fault_flag_n_oe(fOe), .bridge_in_first(inFirst), .bridge_in_second(inSecond),
      .sleep_request_n(sleepN), .faultLineN(faultLineN), .wakeDone(wakeDone));
   dhbmc_top #(.OCP_RETRY_CYCLES(RETRY), .WAKE_CYCLES(WAKE)) i_dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .sleep_request_n(sleepN), .supply_low_lockout(lowSupply),
      .overtemp_shutdown(hotDie), .bridge_in_first(inFirst), .bridge_in_second(inSecond),
      .chop_trip(chopTrip), .ocp_high_side(ocpHigh), .ocp_low_side(ocpLow),
      .out_first_high(fh), .out_first_low(fl), .out_second_high(sh), .out_second_low(sl),
      .fault_flag_n_out(fOut), .fault_flag_n_oe(fOe));
   assign fets = {fh, fl, sh, sl};
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge ref_clk);
   endtask
   task automatic conclude();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // A leg never has both FETs on
   always @(negedge ref_clk) begin
      if (((fh & fl) | (sh & sl)) !== 2'b00) check(8'h01, 8'h00);
   end
   initial begin
      #(20 * 12000);
      miscompares++;
      conclude();
   end
   initial begin
      cyc(4);
      rst_n = 1'b1;
      cyc(WAKE + DEAD_CYCLES + 4);
      check({7'h00, wakeDone}, 8'h01);
      for (k = 0; k < 6; k++) begin
         {reqFirst, reqSecond} = rows[k][11:8];
         cyc(DEAD_CYCLES + 4);
         check(fets, rows[k][7:0]);
      end
      $display("truth table done");
      reqFirst = 2'b01;
      reqSecond = 2'b00;
      chopTrip = 2'b01;
      n = 0;
      while (!(fl[0] && sl[0]) && n < 1100) begin cyc(1); n++; end
      check({5'h00, fh[0], fl[0], sl[0]}, 8'h03);
      n = 0;
      while (!fh[0] && n < 1100) begin cyc(1); n++; end
      check({7'h00, fh[0]}, 8'h01);
      n = 0;
      while (fh[0] && n < 1100) begin cyc(1); n++; end
      check({7'h00, n >= BLANK_CYCLES - DEAD_CYCLES - 6}, 8'h01);
      chopTrip = 2'b00;
      cyc(1100);
      check(fets, 8'h41);
      $display("chopping done");
      reqFirst = 2'b11;
      cyc(DEAD_CYCLES + 4);
      for (k = 0; k < 2; k++) begin
         ocpHigh = k ? 2'b00 : 2'b01;
         ocpLow = k ? 2'b10 : 2'b00;
         n = 0;
         while (!fOe && n < 400) begin cyc(1); n++; end
         check({7'h00, n >= OCP_DEG_CYCLES}, 8'h01);
         cyc(3);
         check(fets, k ? 8'h41 : 8'h82);
         check({7'h00, faultLineN}, 8'h00);
         ocpHigh = 2'b00;
         ocpLow = 2'b00;
         cyc(RETRY + DEAD_CYCLES + 8);
         check({fets[6:0], faultLineN}, 8'h87);
      end
      $display("overcurrent done");
      hotDie = 1'b1;
      cyc(4);
      check({fets[6:0], faultLineN}, 8'h00);
      hotDie = 1'b0;
      cyc(DEAD_CYCLES + 4);
      check({fets[6:0], faultLineN}, 8'h87);
      lowSupply = 1'b1;
      cyc(2);
      check({fets[6:0], faultLineN}, 8'h00);
      lowSupply = 1'b0;
      cyc(2);
      check(fets, 8'h00);
      cyc(WAKE + DEAD_CYCLES + 4);
      check(fets, 8'hC3);
      $display("temperature and supply done");
      reqSleepN = 1'b0;
      cyc(2);
      check({fets[6:0], faultLineN}, 8'h01);
      {reqFirst, reqSecond} = 4'h3;
      cyc(5);
      check(fets, 8'h00);
      reqSleepN = 1'b1;
      cyc(WAKE - 2);
      check(fets, 8'h00);
      cyc(DEAD_CYCLES + 12);
      check(fets, 8'h3C);
      rst_n = 1'b0;
      cyc(2);
      check({fets[6:0], faultLineN}, 8'h01);
      $display("sleep and reset done");
      conclude();
   end
endmodule
`default_nettype wire
